// ### rtl/srs_consts.svh
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
// counter width and stage lengths in oscillator-select clock cycles
`define SRS_CNT_W        12
`define SRS_LONG_CYC     4096
`define SRS_SHORT_CYC    32
`define SRS_DRIVE_CYC    32
`define SRS_HOLD_CYC     32
`define SRS_PIN_MIN_CYC  67
// restart vectors
`define SRS_VEC_USER     16'hFFFE
`define SRS_VEC_MON      16'hFEFE
// reset cause bit positions and the power-on cause value
`define SRS_F_POR        0
`define SRS_F_PIN        1
`define SRS_F_WDOG       2
`define SRS_F_BADOP      3
`define SRS_F_BADAD      4
`define SRS_F_LV         5
`define SRS_F_RESET      6'h01
`endif

// ### rtl/srs_pkg.sv
package srs_pkg;
  typedef enum logic [3:0] {
    ST_POR  = 4'b0000,
    ST_LVH  = 4'b0001,
    ST_LONG = 4'b0010,
    ST_DRV  = 4'b0011,
    ST_INTERNAL_RESET_LINE = 4'b0100,
    ST_RUN  = 4'b0101,
    ST_WAIT = 4'b0110,
    ST_STOP = 4'b0111,
    ST_SREC = 4'b1000,
    ST_EXT  = 4'b1001
  } srs_state_t;

  typedef struct packed {
    srs_state_t  st;
    logic [5:0]  cause;
    logic [6:0]  pin_cnt;
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic        wd_prev;
  } srs_seq_t;

  typedef struct packed {
    logic [11:0] cnt;
  } srs_cnt_t;

  typedef struct packed {
    logic       gen;
    logic [1:0] ph;
  } srs_div_t;
endpackage : srs_pkg

// ### rtl/srs_if.sv
`timescale 1ns/1ps
`default_nettype none
// ties the sequencer to its counter and clock divider
interface srs_if;
  logic        tick;     // oscillator-select falling edge
  logic        clr;      // hold counter at zero
  logic [11:0] cnt;      // counter value
  logic        ovf;      // counter wrap pulse
  logic        gen_en;   // generator output enable
  logic        cpu_en;   // processor clock enable
  logic        per_en;   // peripheral clock enable
  logic        gen_clk;  // generator output clock
  logic        bus_ce;   // bus clock pulse
  modport seq (output tick, clr, gen_en, cpu_en, per_en,
               input cnt, ovf, gen_clk, bus_ce);
  modport cnt_m (input tick, clr, output cnt, ovf);
  modport div_m (input tick, gen_en, cpu_en, per_en,
                 output gen_clk, bus_ce);
endinterface : srs_if
`default_nettype wire

// ### rtl/srs_stab_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "srs_consts.svh"
module srs_stab_counter (
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_sys_rst,  // sync reset, high
  input  wire logic i_ce,       // clock enable
  srs_if.cnt_m      c           // counter side
);
  srs_pkg::srs_cnt_t r_r;
  srs_pkg::srs_cnt_t r_nxt;

  // ===========================================================
  // counter advances once per oscillator falling edge
  always_comb begin
    r_nxt = r_r;
    if (c.clr) begin
      r_nxt.cnt = 12'h000;
    end else if (c.tick) begin
      r_nxt.cnt = r_r.cnt + 12'h001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      r_r <= '0;
    end else if (i_ce) begin
      r_r <= r_nxt;
    end
  end

  assign c.cnt = r_r.cnt;
  // wrap pulse clocks the watchdog prescaler
  assign c.ovf = i_ce & c.tick & ~c.clr & (&r_r.cnt);
endmodule : srs_stab_counter
`default_nettype wire

// ### rtl/srs_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module srs_clk_div (
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_sys_rst,  // sync reset, high
  input  wire logic i_ce,       // clock enable
  srs_if.div_m      d           // divider side
);
  srs_pkg::srs_div_t r_r;
  srs_pkg::srs_div_t r_nxt;

  // ===========================================================
  // generator output is osc/2, bus is generator/2 = osc/4
  always_comb begin
    r_nxt = r_r;
    if (!d.gen_en) begin
      r_nxt.gen = 1'b0;
      r_nxt.ph  = 2'h0;
    end else if (d.tick) begin
      r_nxt.gen = ~r_r.gen;
      r_nxt.ph  = r_r.ph + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      r_r <= '0;
    end else if (i_ce) begin
      r_r <= r_nxt;
    end
  end

  assign d.gen_clk = r_r.gen;
  // pulse once per two generator periods while peripherals run
  assign d.bus_ce  = i_ce & d.tick & d.gen_en & d.per_en
                     & r_r.gen & r_r.ph[1];
endmodule : srs_clk_div
`default_nettype wire

// ### rtl/srs_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "srs_consts.svh"
module srs_seq #(
  parameter int LONG_CYC = `SRS_LONG_CYC  // oscillator wait length
) (
  input  wire logic        i_clk_sys,        // system clock
  input  wire logic        i_sys_rst,        // sync reset, high
  input  wire logic        i_ce,             // clock enable
  input  wire logic        i_osc_fall,       // osc-select falling edge
  input  wire logic        i_power_on_pulse, // async power-on pulse
  input  wire logic        i_lv_detect,      // async low-voltage level
  input  wire logic        i_wdog_req,       // async watchdog request
  input  wire logic        i_rst_pin_i,      // async reset pin level
  input  wire logic        i_bad_opcode,     // illegal opcode pulse
  input  wire logic        i_stop_exec,      // stop instruction pulse
  input  wire logic        i_wait_exec,      // wait instruction pulse
  input  wire logic        i_opcode_fetch,   // current fetch is opcode
  input  wire logic        i_unmapped,       // address is unmapped
  input  wire logic        i_wake,           // interrupt or break
  input  wire logic        i_monitor_mode,   // monitor mode active
  input  wire logic        i_stop_allow,     // stop instruction allowed
  input  wire logic        i_watchdog_disable,   // watchdog off
  input  wire logic        i_lv_monitor_power_off, // lv monitor off
  input  wire logic        i_lv_reset_disable,   // lv reset off
  input  wire logic        i_short_stop_recovery, // short recovery
  output logic             o_rst_pin_o,      // pin drive value
  output logic             o_rst_pin_oe,     // pin drive enable
  output logic             o_internal_reset_line, // internal reset
  output logic             o_cpu_clk_en,     // processor clocks on
  output logic             o_per_clk_en,     // peripheral clocks on
  output logic             o_gen_clock_out,  // generator output
  output logic             o_bus_ce,         // bus clock pulse
  output logic             o_wdog_tick,      // watchdog clock pulse
  output logic [15:0]      o_vector,         // restart vector
  output logic [5:0]       o_reset_cause_register, // cause flags
  output logic [11:0]      o_stab_count      // counter value
);
  // each stage but the release stage after a pin reset starts from a cleared counter, so its last tick is the
  // one seen while the count still reads the stage length minus one
  localparam logic [11:0] LONG_M1  = 12'(LONG_CYC - 1);
  localparam logic [11:0] SHORT_M1 = 12'(`SRS_SHORT_CYC - 1);
  localparam logic [11:0] DRV_M1   = 12'(`SRS_DRIVE_CYC - 1);
  localparam logic [11:0] HOLD_M1  = 12'(`SRS_HOLD_CYC - 1);
  localparam logic [6:0]  PIN_MIN  = 7'(`SRS_PIN_MIN_CYC);

  // ===========================================================
  // shared glue
  srs_if bus ();

  srs_stab_counter u_cnt (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .c         (bus)
  );

  srs_clk_div u_div (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .d         (bus)
  );

  // stage end: last oscillator edge of a stage begun at zero
  function automatic logic stage_end(input logic        tick,
                                     input logic [11:0] cnt,
                                     input logic [11:0] last);
    stage_end = tick & (cnt == last);
  endfunction : stage_end

  srs_pkg::srs_seq_t r_r;
  srs_pkg::srs_seq_t r_nxt;

  logic por_s;
  logic lv_s;
  logic wd_s;
  logic pin_lo_s;
  logic lv_go;
  logic wd_go;
  logic in_rst;
  logic rst_ld;   // move into a reset stage this cycle
  logic clr_c;

  // synchronised levels, second flop only
  assign por_s    = r_r.sy2[0];
  assign lv_s     = r_r.sy2[1];
  assign wd_s     = r_r.sy2[2];
  assign pin_lo_s = ~r_r.sy2[3];

  // low voltage is a level: it holds the sequencer until it goes away
  // watchdog is an edge: a request held high resets only once
  assign lv_go  = lv_s & ~i_lv_monitor_power_off
                  & ~i_lv_reset_disable;
  assign wd_go  = wd_s & ~r_r.wd_prev & ~i_watchdog_disable;
  // stages in which we pull the pin low ourselves; internal sources
  // other than low voltage are ignored here because a reset is already under way
  assign in_rst = (r_r.st == srs_pkg::ST_POR)
                | (r_r.st == srs_pkg::ST_LVH)
                | (r_r.st == srs_pkg::ST_LONG)
                | (r_r.st == srs_pkg::ST_DRV);

  // ===========================================================
  // sequencer next state
  always_comb begin
    r_nxt     = r_r;
    rst_ld    = 1'b0;
    clr_c     = 1'b0;
    // async pins pass two flops before anyone reads them
    r_nxt.sy1 = {i_rst_pin_i, i_wdog_req, i_lv_detect,
                 i_power_on_pulse};
    r_nxt.sy2 = r_r.sy1;
    r_nxt.wd_prev = wd_s;

    case (r_r.st)
      srs_pkg::ST_POR: begin
        r_nxt.cause = `SRS_F_RESET;
        r_nxt.st    = srs_pkg::ST_LONG;
        clr_c       = 1'b1;
      end
      srs_pkg::ST_LVH: begin
        // counter stays clear until the supply is back
        clr_c = 1'b1;
        if (!lv_s) begin
          r_nxt.st = srs_pkg::ST_LONG;
        end
      end
      srs_pkg::ST_LONG: begin
        if (stage_end(bus.tick, bus.cnt, LONG_M1)) begin
          r_nxt.st = srs_pkg::ST_DRV;
          clr_c    = 1'b1;
        end
      end
      srs_pkg::ST_DRV: begin
        if (stage_end(bus.tick, bus.cnt, DRV_M1)) begin
          r_nxt.st = srs_pkg::ST_INTERNAL_RESET_LINE;
          clr_c    = 1'b1;
        end
      end
      srs_pkg::ST_INTERNAL_RESET_LINE: begin
        if (stage_end(bus.tick, bus.cnt, HOLD_M1)) begin
          r_nxt.st = srs_pkg::ST_RUN;
        end
      end
      srs_pkg::ST_RUN: begin
        // a stop that is not allowed is caught below as a bad opcode
        if (i_stop_exec && i_stop_allow) begin
          r_nxt.st = srs_pkg::ST_STOP;
        end else if (i_wait_exec) begin
          r_nxt.st = srs_pkg::ST_WAIT;
        end
      end
      srs_pkg::ST_WAIT: begin
        // peripherals keep running; only the processor sleeps
        if (i_wake) begin
          r_nxt.st = srs_pkg::ST_RUN;
        end
      end
      srs_pkg::ST_STOP: begin
        clr_c = 1'b1;
        if (i_wake) begin
          r_nxt.st = srs_pkg::ST_SREC;
        end
      end
      srs_pkg::ST_SREC: begin
        // recovery length follows the option live; change it only in run
        if (stage_end(bus.tick, bus.cnt,
                      i_short_stop_recovery ? SHORT_M1
                                            : LONG_M1)) begin
          r_nxt.st = srs_pkg::ST_RUN;
        end
      end
      srs_pkg::ST_EXT: begin
        // counter left alone: pin reset does not clear it
        // limitation: the release stage then waits for the count to pass
        // the hold length, which can take up to one full counter wrap
        if (!pin_lo_s) begin
          r_nxt.st = srs_pkg::ST_INTERNAL_RESET_LINE;
        end else if (bus.tick && r_r.pin_cnt != PIN_MIN) begin
          r_nxt.pin_cnt = r_r.pin_cnt + 7'h01;
        end
        if (r_r.pin_cnt == PIN_MIN) begin
          r_nxt.cause[`SRS_F_PIN] = 1'b1;
        end
      end
      default: begin
        r_nxt.st = srs_pkg::ST_POR;
      end
    endcase

    // reset sources, highest priority first; flags only ever set
    // power-on is the one clear: it wins over any flag set in the same
    // cycle, because its flag must be the only one left standing
    if (por_s) begin
      r_nxt.st    = srs_pkg::ST_POR;
      r_nxt.cause = `SRS_F_RESET;
    end else if (lv_go && r_r.st != srs_pkg::ST_LVH
                 && r_r.st != srs_pkg::ST_POR) begin
      r_nxt.st = srs_pkg::ST_LVH;
      r_nxt.cause[`SRS_F_LV] = 1'b1;
      rst_ld = 1'b1;
    end else if (!in_rst) begin
      if (wd_go) begin
        r_nxt.cause[`SRS_F_WDOG] = 1'b1;
        rst_ld = 1'b1;
      end
      if (r_r.st == srs_pkg::ST_RUN && i_bad_opcode) begin
        r_nxt.cause[`SRS_F_BADOP] = 1'b1;
        rst_ld = 1'b1;
      end
      if (r_r.st == srs_pkg::ST_RUN && i_stop_exec
          && !i_stop_allow) begin
        r_nxt.cause[`SRS_F_BADOP] = 1'b1;
        rst_ld = 1'b1;
      end
      if (r_r.st == srs_pkg::ST_RUN && i_opcode_fetch
          && i_unmapped) begin
        r_nxt.cause[`SRS_F_BADAD] = 1'b1;
        rst_ld = 1'b1;
      end
      if (rst_ld) begin
        r_nxt.st = srs_pkg::ST_DRV;
      end else if (pin_lo_s && r_r.st != srs_pkg::ST_EXT
                   && r_r.st != srs_pkg::ST_INTERNAL_RESET_LINE) begin
        // our own drive is over, so a low pin is someone else
        r_nxt.st      = srs_pkg::ST_EXT;
        r_nxt.pin_cnt = 7'h00;
      end
    end
  end

  // ===========================================================
  // one register for all sequencer state
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      r_r     <= '0;
      // pin flops reset high, so the idle pin does not look like a
      // fresh external reset in the first cycles after release
      r_r.sy1 <= 4'h8;
      r_r.sy2 <= 4'h8;
    end else if (i_ce) begin
      r_r <= r_nxt;
    end
  end

  // ===========================================================
  // counter and divider control
  assign bus.tick   = i_osc_fall;
  assign bus.clr    = clr_c | rst_ld;
  // generator stays on through power-on, off only in stop and stop recovery
  assign bus.gen_en = (r_r.st != srs_pkg::ST_STOP)
                    & (r_r.st != srs_pkg::ST_SREC);
  // processor clocks run only in run; wait keeps the peripherals going
  assign bus.cpu_en = (r_r.st == srs_pkg::ST_RUN);
  assign bus.per_en = (r_r.st == srs_pkg::ST_RUN)
                    | (r_r.st == srs_pkg::ST_WAIT);

  // ===========================================================
  // outputs
  // open drain: we only pull low and leave the high level to the
  // pull-up, so other parties may share the pin
  assign o_rst_pin_o  = 1'b0;
  assign o_rst_pin_oe = in_rst;
  // every module sees reset until the release stage ends
  assign o_internal_reset_line = in_rst
                               | (r_r.st == srs_pkg::ST_INTERNAL_RESET_LINE)
                               | (r_r.st == srs_pkg::ST_EXT);
  assign o_cpu_clk_en    = bus.cpu_en;
  assign o_per_clk_en    = bus.per_en;
  assign o_gen_clock_out = bus.gen_clk;
  assign o_bus_ce        = bus.bus_ce;
  assign o_wdog_tick     = bus.ovf;
  // vector follows the mode input directly; it has no state of its own
  assign o_vector        = i_monitor_mode ? `SRS_VEC_MON
                                          : `SRS_VEC_USER;
  assign o_reset_cause_register = r_r.cause;
  assign o_stab_count    = bus.cnt;
endmodule : srs_seq
`default_nettype wire

// ### verif/srs_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// checker on the sequencer ports
module srs_seq_sva #(
  parameter int LONG_CYC = 4096  // oscillator wait length
) (
  input wire logic        i_clk_sys,              // clock
  input wire logic        i_sys_rst,              // reset
  input wire logic        i_osc_fall,             // osc tick
  input wire logic        i_power_on_pulse,       // power-on
  input wire logic        i_monitor_mode,         // monitor
  input wire logic        o_rst_pin_o,            // pin value
  input wire logic        o_rst_pin_oe,           // pin enable
  input wire logic        o_internal_reset_line,  // reset line
  input wire logic        o_cpu_clk_en,           // cpu clocks
  input wire logic        o_per_clk_en,           // per clocks
  input wire logic        o_bus_ce,               // bus pulse
  input wire logic        o_wdog_tick,            // wrap pulse
  input wire logic [15:0] o_vector,               // vector
  input wire logic [5:0]  o_reset_cause_register, // flags
  input wire logic [11:0] o_stab_count            // counter
);
  // one clock domain, so one default for all
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_pin_open_drain: assert property (
    o_rst_pin_oe |-> !o_rst_pin_o) else $error("pin driven high");
  a_vector_select: assert property (
    o_vector == (i_monitor_mode ? 16'hFEFE : 16'hFFFE))
    else $error("wrong vector");
  a_clocks_in_reset: assert property (
    o_internal_reset_line |-> !o_cpu_clk_en && !o_per_clk_en)
    else $error("clock during reset");
  a_pin_under_reset: assert property (
    o_rst_pin_oe |-> o_internal_reset_line) else $error("pin alone");
  a_bus_pulse_gate: assert property (
    o_bus_ce |-> o_per_clk_en && i_osc_fall) else $error("bad bus pulse");
  a_wrap_tick: assert property (
    o_wdog_tick |-> i_osc_fall && o_stab_count == 12'hFFF)
    else $error("tick without wrap");
  a_count_step: assert property (
    $changed(o_stab_count) && o_stab_count != 12'h000 |->
    $past(i_osc_fall) && o_stab_count == $past(o_stab_count) + 12'h001)
    else $error("counter jumped");
  a_flags_sticky: assert property (
    !i_power_on_pulse [*4] |-> (o_reset_cause_register &
    $past(o_reset_cause_register)) == $past(o_reset_cause_register))
    else $error("flag lost");
  a_wdog_flag_drive: assert property (
    $rose(o_reset_cause_register[2]) |-> o_rst_pin_oe &&
    o_stab_count == 12'h000) else $error("watchdog reset late");
  a_pin_flag_ext: assert property (
    $rose(o_reset_cause_register[1]) |-> o_internal_reset_line &&
    !o_rst_pin_oe) else $error("pin flag wrong");
endmodule : srs_seq_sva
bind srs_seq srs_seq_sva #(.LONG_CYC(LONG_CYC)) srs_seq_sva_inst (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_osc_fall(i_osc_fall),
  .i_power_on_pulse(i_power_on_pulse), .i_monitor_mode(i_monitor_mode),
  .o_rst_pin_o(o_rst_pin_o), .o_rst_pin_oe(o_rst_pin_oe),
  .o_internal_reset_line(o_internal_reset_line),
  .o_cpu_clk_en(o_cpu_clk_en), .o_per_clk_en(o_per_clk_en),
  .o_bus_ce(o_bus_ce), .o_wdog_tick(o_wdog_tick), .o_vector(o_vector),
  .o_reset_cause_register(o_reset_cause_register),
  .o_stab_count(o_stab_count));
`default_nettype wire

// ### verif/srs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// oscillator and reset pin outside the sequencer
module srs_far_model (
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_run,      // oscillator running
  input  wire logic i_ext_low,  // outside party pulls pin low
  input  wire logic i_pin_o,    // device drive value
  input  wire logic i_pin_oe,   // device drive enable
  output logic      o_osc_fall, // osc-select falling edge pulse
  output logic      o_pin_n     // resolved pin level, low = reset
);
  logic [1:0] ph_r;
  // one falling edge every fourth system clock, none until running
  always_ff @(posedge i_clk_sys) begin
    if (!i_run) ph_r <= 2'h0;
    else ph_r <= ph_r + 2'h1;
  end
  assign o_osc_fall = i_run && ph_r == 2'h3;
  // wired low by either party, pull-up otherwise
  assign o_pin_n = ~((i_pin_oe && !i_pin_o) || i_ext_low);
endmodule : srs_far_model
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// sequencer bench
module tb_top;
  localparam int LC = 64;  // short oscillator wait keeps runs brief
  logic        clk, rst, pwr, lv, wd, bad, stp, wt, opf, unm, wake, mon;
  logic        sal, wdis, lvoff, lvdis, ssr, run, ext_low, osc, pin_n;
  logic        pin_o, pin_oe, internal_reset_line, cpu, per, gen, bus, wtk, ce;
  logic [15:0] vec, n_pin, n_internal_reset_line, n_off, n_bus, n_tick, n_wt, n_gen;
  logic [5:0]  cause;
  logic [11:0] cnt, c0;
  logic [5:0]  exp_c [4] = '{6'h05, 6'h0D, 6'h0D, 6'h1D};
  int          error_cnt, samples_checked;
  srs_far_model srs_far_model_inst (.i_clk_sys(clk), .i_run(run),
    .i_ext_low(ext_low), .i_pin_o(pin_o), .i_pin_oe(pin_oe),
    .o_osc_fall(osc), .o_pin_n(pin_n));
  srs_seq #(.LONG_CYC(LC)) srs_seq_inst (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce), .i_osc_fall(osc),
    .i_power_on_pulse(pwr), .i_lv_detect(lv), .i_wdog_req(wd),
    .i_rst_pin_i(pin_n), .i_bad_opcode(bad), .i_stop_exec(stp),
    .i_wait_exec(wt), .i_opcode_fetch(opf), .i_unmapped(unm),
    .i_wake(wake), .i_monitor_mode(mon), .i_stop_allow(sal),
    .i_watchdog_disable(wdis), .i_lv_monitor_power_off(lvoff),
    .i_lv_reset_disable(lvdis), .i_short_stop_recovery(ssr),
    .o_rst_pin_o(pin_o), .o_rst_pin_oe(pin_oe),
    .o_internal_reset_line(internal_reset_line), .o_cpu_clk_en(cpu),
    .o_per_clk_en(per), .o_gen_clock_out(gen), .o_bus_ce(bus),
    .o_wdog_tick(wtk), .o_vector(vec), .o_reset_cause_register(cause),
    .o_stab_count(cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // spans in osc ticks, sampled before the edge's own updates land
  always @(posedge clk) begin
    if (!rst && osc) begin
      n_tick++;
      if (pin_oe) n_pin++;
      if (internal_reset_line) n_internal_reset_line++;
      if (!cpu) n_off++;
      if (internal_reset_line && gen) n_gen++;
    end
    if (bus) n_bus++;
    if (wtk) n_wt++;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic clr;
    {n_pin, n_internal_reset_line, n_off, n_bus, n_tick, n_wt, n_gen} = '0;
  endtask : clr
  task automatic chk(input logic [15:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  // bounded wait for clocks back on and reset gone
  task automatic wait_run;
    int k;
    k = 0;
    while (!(cpu === 1'b1 && internal_reset_line === 1'b0) && k < 30000) begin
      step(1);
      k++;
    end
    if (k >= 30000) chk(16'h0000, 16'h0001, "hang");
  endtask : wait_run
  // leaves the next edge free of a tick
  task automatic sync_tick;
    while (osc !== 1'b1) step(1);
    step(1);
  endtask : sync_tick
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    error_cnt++;
    $display("unexpected at %0t: timeout", $time);
    finish_test();
  end
  initial begin
    {pwr, lv, wd, bad, stp, wt, opf, unm, wake, mon} = '0;
    {sal, wdis, lvoff, lvdis, ssr, run, ext_low, rst} = 8'h01;
    ce = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    clr();
    step(16);
    rst = 1'b0;
    step(2);
    run = 1'b1;
    clr();
    wait_run();
    chk(n_pin, 16'(LC + 32), "power pin");
    chk(n_internal_reset_line, 16'(LC + 64), "power release");
    chk(16'(n_gen != 0), 16'h0001, "generator");
    chk(cause, 6'h01, "power cause");
    chk(vec, 16'hFFFE, "vector");
    mon = 1'b1;
    step(1);
    chk(vec, 16'hFEFE, "monitor vector");
    mon = 1'b0;
    clr();
    step(256);
    chk(n_bus, n_tick >> 2, "bus rate");
    $display("test power and bus done");
    for (int k = 0; k < 4; k++) begin
      clr();
      case (k)
        0: wd = 1'b1;
        1: bad = 1'b1;
        2: stp = 1'b1;
        default: {opf, unm} = 2'h3;
      endcase
      step(1);
      {bad, stp, opf, unm} = '0;
      step(8);
      wait_run();
      wd = 1'b0;
      chk(n_pin, 16'h0020, "drive span");
      chk(n_internal_reset_line, 16'h0040, "reset span");
      chk(cause, exp_c[k], "cause");
    end
    {wdis, wd, unm} = 3'h7;
    step(40);
    chk({internal_reset_line, cpu}, 16'h0001, "refused");
    {wd, unm} = '0;
    step(8);
    wdis = 1'b0;
    for (int k = 0; k < 2; k++) begin
      {lvoff, lvdis, lv} = k ? 3'h3 : 3'h5;
      step(40);
      chk(internal_reset_line, 16'h0000, "lv refused");
      lv = 1'b0;
      step(8);
      {lvoff, lvdis} = '0;
    end
    $display("test internal sources done");
    clr();
    c0 = cnt;
    ext_low = 1'b1;
    step(300);
    chk(internal_reset_line, 16'h0001, "pin halt");
    chk(cnt, 12'(c0 + n_tick), "pin keeps count");
    ext_low = 1'b0;
    step(8);
    wait_run();
    chk(cause, 6'h1F, "pin flag");
    wt = 1'b1;
    step(1);
    wt = 1'b0;
    step(4);
    chk({cpu, per}, 16'h0001, "wait clocks");
    wake = 1'b1;
    step(4);
    chk(cpu, 16'h0001, "wait wake");
    wake = 1'b0;
    $display("test pin and wait done");
    sal = 1'b1;
    for (int k = 0; k < 2; k++) begin
      ssr = (k == 0);
      stp = 1'b1;
      step(1);
      stp = 1'b0;
      step(8);
      chk(cnt, 16'h0000, "stop count");
      sync_tick();
      clr();
      wake = 1'b1;
      wait_run();
      wake = 1'b0;
      chk(n_off, k ? 16'(LC) : 16'h0020, "stop recovery");
    end
    clr();
    lv = 1'b1;
    step(20);
    chk({pin_oe, internal_reset_line}, 16'h0003, "low voltage hold");
    lv = 1'b0;
    step(8);
    wait_run();
    chk(cause, 6'h3F, "low voltage flag");
    pwr = 1'b1;
    step(4);
    pwr = 1'b0;
    step(8);
    wait_run();
    chk(cause, 6'h01, "power clears");
    $display("test stop and power done");
    ce = 1'b0;
    c0 = cnt;
    step(40);
    chk(cnt, c0, "enable freezes");
    ce = 1'b1;
    clr();
    c0 = cnt;
    step(16400);
    chk(n_wt, 16'h0001, "wrap tick");
    chk(cnt, 12'(c0 + n_tick), "free count");
    $display("test counter done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
